// ---- bench/search_replace_extfunc_exec_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module search_replace_extfunc_exec_tb;
    typedef struct packed {
        logic [23:0] w;
        logic [47:0] a, q;
        logic [14:0] b;
        logic        ef, aw, iw;
        logic [47:0] xa;
        logic [14:0] xi;
    } srx_row_t;
    logic        mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        instr_valid = 0, instr_lower = 0, ext_cond = 0, slow = 0, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [23:0] instr_word = 0;
    logic [47:0] acc_in = 0, mask_in = 0, acc_out, mem_wdata, mem_rdata;
    logic [14:0] index_in = 0, index_out, mem_addr, chan_start, chan_term, cond_code;
    logic [2:0]  chan_num;
    logic        pready, pslverr, instr_ready, done, exit_full, exit_half, acc_we, index_we;
    logic        mem_req, mem_we, mem_ack, chan_act, cond_select, overflow_irq;
    int          n_fail = 0, checks_done = 0;
    srx_row_t    rows [14] = '{
        '{24'hd08100, 48'h7, 48'h0, 15'd4, 1'b1, 1'b0, 1'b1, 48'h0, 15'd2},
        '{24'hd08100, 48'h0, 48'h0, 15'd4, 1'b1, 1'b0, 1'b1, 48'h0, 15'd1},
        '{24'hd08100, 48'h9, 48'h0, 15'd4, 1'b0, 1'b0, 1'b1, 48'h0, 15'd0},
        '{24'hd00102, 48'h7, 48'h0, 15'd4, 1'b1, 1'b0, 1'b0, 48'h0, 15'd0},
        '{24'hd48100, 48'h4, 48'h0, 15'd4, 1'b1, 1'b0, 1'b1, 48'h0, 15'd2},
        '{24'hd40104, 48'hffffffffffff, 48'h0, 15'd0, 1'b1, 1'b0, 1'b0, 48'h0, 15'd0},
        '{24'hd88100, 48'h4, 48'h4, 15'd4, 1'b1, 1'b0, 1'b1, 48'h0, 15'd2},
        '{24'hdc8100, 48'h0, 48'h1, 15'd4, 1'b1, 1'b0, 1'b1, 48'h0, 15'd3},
        '{24'hdc8100, 48'h7, 48'h7, 15'd4, 1'b0, 1'b0, 1'b1, 48'h0, 15'd0},
        '{24'he00200, 48'h5, 48'h0, 15'd0, 1'b1, 1'b1, 1'b0, 48'hf, 15'd0},
        '{24'he40200, 48'h4, 48'h0, 15'd0, 1'b1, 1'b1, 1'b0, 48'hb, 15'd0},
        '{24'he80200, 48'h0, 48'h0, 15'd0, 1'b1, 1'b1, 1'b0, 48'hc, 15'd0},
        '{24'hec0200, 48'h0, 48'h0, 15'd0, 1'b1, 1'b1, 1'b0, 48'hb, 15'd0},
        '{24'h000100, 48'h0, 48'h0, 15'd0, 1'b1, 1'b0, 1'b0, 48'h0, 15'd0}};

    srx_exec i_dut (.*);
    srx_mem_model i_mem (.*);

    // ****************************************************************
    // Clock, shared tasks and watchdog
    // ****************************************************************
    always #5 mclk = ~mclk;

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    // Issue one instruction and wait for its completion pulse
    task automatic ex(input logic [23:0] w, input logic lo, input logic [47:0] a, input logic [14:0] b);
        int n;
        n = 0;
        @(posedge mclk);
        instr_word  <= w;
        instr_lower <= lo;
        acc_in      <= a;
        index_in    <= b;
        instr_valid <= 1'b1;
        do @(posedge mclk); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
        do @(negedge mclk); while (done !== 1'b1 && ++n < 300);
        if (done !== 1'b1) begin
            n_fail++;
            $display("MISMATCH %0t instruction never completed", $time);
            summarize();
        end
    endtask : ex

    // One APB transfer, held until pready at a rising edge
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= ad;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge mclk);
    endtask : apb

    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        summarize();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        i_mem.mem[15'h100] = 48'h5;
        i_mem.mem[15'h101] = 48'hffffffffffff;
        i_mem.mem[15'h102] = 48'h7;
        i_mem.mem[15'h103] = 48'h3;
        i_mem.mem[15'h104] = 48'h0;
        i_mem.mem[15'h200] = 48'ha;
        i_mem.mem[15'h201] = 48'h7fffffffffff;
        i_mem.mem[15'h003] = 48'h155;
        repeat (6) @(posedge mclk);
        chk({done, mem_req, instr_ready, overflow_irq}, 4'h2);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            @(posedge mclk);
            slow <= 1'(i & 1);
            mask_in <= rows[i].q;
            ex(rows[i].w, 1'b0, rows[i].a, rows[i].b);
            chk({exit_full, exit_half}, {rows[i].ef, !rows[i].ef});
            chk({acc_we, index_we}, {rows[i].aw, rows[i].iw});
            if (rows[i].aw) chk(acc_out, rows[i].xa);
            if (rows[i].iw) chk(index_out, rows[i].xi);
        end
        chk(i_mem.mem[15'h200], 48'hb);
        ex(24'he80201, 1'b0, 48'h0, 15'd0);
        chk(acc_out, 48'h800000000000);
        chk(overflow_irq, 1'b0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h5);
        apb(1'b1, 12'h000, 32'h1);
        chk(overflow_irq, 1'b1);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h1);
        ex(24'hf38058, 1'b0, 48'h0, 15'd0);
        chk(exit_full, 1'b1);
        ex(24'hf38059, 1'b1, 48'h0, 15'd0);
        chk(exit_half, 1'b1);
        @(posedge mclk) ext_cond <= 1'b1;
        ex(24'hf39000, 1'b0, 48'h0, 15'd0);
        chk(exit_full, 1'b1);
        for (int k = 0; k < 2; k++) begin
            ex(24'hf00040, 1'(k), 48'h0, 15'd5);
            chk({cond_select, cond_code}, {1'b1, 15'h040});
        end
        ex(24'hf18150, 1'b0, 48'h0, 15'd7);
        chk({chan_act, chan_num, chan_start, chan_term}, {1'b1, 3'd3, 15'h150, 15'h155});
        chk(i_mem.mem[15'h003], 48'h000150000155);
        apb(1'b1, 12'h000, 32'h2);
        chk(overflow_irq, 1'b0);
        ex(24'hd08100, 1'b0, 48'h7, 15'd4);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, 12'hffc, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        summarize();
    end
endmodule : search_replace_extfunc_exec_tb
`default_nettype wire

// ---- bench/srx_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Core storage on the far side of the block
// ****************************************************************
module srx_mem_model (
    input  wire logic                       mclk,
    input  wire logic                       slow,
    input  wire logic                       mem_req,
    input  wire logic                       mem_we,
    input  wire logic [srx_pkg::ADDR_W-1:0] mem_addr,
    input  wire logic [srx_pkg::WORD_W-1:0] mem_wdata,
    output logic                            mem_ack,
    output logic [srx_pkg::WORD_W-1:0]      mem_rdata
);
    logic [srx_pkg::WORD_W-1:0] mem [0:32767];
    logic [srx_pkg::WORD_W-1:0] last = '0;
    logic                       ph   = 1'b0;
    // Slow mode acknowledges every other cycle; idle data is scrambled
    assign mem_ack   = mem_req & (ph | ~slow);
    assign mem_rdata = (mem_ack & ~mem_we) ? mem[mem_addr] : ~last;
    // Writes land at the acknowledging edge
    always @(posedge mclk) begin
        ph <= ~ph;
        if (mem_ack & ~mem_we)
            last <= mem[mem_addr];
        if (mem_ack & mem_we)
            mem[mem_addr] <= mem_wdata;
    end
endmodule : srx_mem_model
`default_nettype wire

// ---- core/srx_exec.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Equality search scans down, counting index
// - Match gives full exit, index locates entry
// - No match by zero gives half exit
// - Designator zero examines only word m
// - Plus and minus zero compare equal
// - Threshold search stops on greater entry
// - Plus zero exceeds minus zero
// - Masked equality search uses mask register
// - Masked threshold search uses mask register
// - Replace add writes sum to storage, accumulator
// - Replace subtract writes difference to both
// - Replace increment writes word plus one
// - Replace decrement writes word minus one
// - Overflow sets indicator; interrupt when selected
// - External function skips index modification
// - Designator: 0 select, 1-6 activate, 7 sense
// - Activation records start in upper half
// - Terminal address taken from lower half
// - Select/sense split into three fields
// - Select acts the same in either position
// - Upper sense skips on condition, else half
// - Lower sense half exits until condition
module srx_exec (
    input  wire logic                       mclk,
    input  wire logic                       sys_rst,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       instr_valid,
    output logic                            instr_ready,
    input  wire logic [23:0]                instr_word,
    input  wire logic                       instr_lower,
    input  wire logic [srx_pkg::WORD_W-1:0] acc_in,
    input  wire logic [srx_pkg::WORD_W-1:0] mask_in,
    input  wire logic [srx_pkg::ADDR_W-1:0] index_in,
    output logic                            done,
    output logic                            exit_full,
    output logic                            exit_half,
    output logic [srx_pkg::WORD_W-1:0]      acc_out,
    output logic                            acc_we,
    output logic [srx_pkg::ADDR_W-1:0]      index_out,
    output logic                            index_we,
    output logic                            mem_req,
    output logic                            mem_we,
    output logic [srx_pkg::ADDR_W-1:0]      mem_addr,
    output logic [srx_pkg::WORD_W-1:0]      mem_wdata,
    input  wire logic                       mem_ack,
    input  wire logic [srx_pkg::WORD_W-1:0] mem_rdata,
    output logic                            chan_act,
    output logic [2:0]                      chan_num,
    output logic [srx_pkg::ADDR_W-1:0]      chan_start,
    output logic [srx_pkg::ADDR_W-1:0]      chan_term,
    output logic                            cond_select,
    output logic [srx_pkg::ADDR_W-1:0]      cond_code,
    input  wire logic                       ext_cond,
    output logic                            overflow_irq
);
    localparam int W = srx_pkg::WORD_W;
    localparam int A = srx_pkg::ADDR_W;

    // ****************************************************************
    // Ones-complement helpers
    // ****************************************************************
    // Ordering key: sign flipped, so plus zero sits above minus zero
    function automatic logic [W-1:0] order_key(input logic [W-1:0] v);
        order_key = {~v[W-1], v[W-2:0]};
    endfunction : order_key

    function automatic logic is_zero(input logic [W-1:0] v);
        is_zero = (v == '0) || (v == '1);
    endfunction : is_zero

    // End-around carry adder
    function automatic logic [W-1:0] oc_add(input logic [W-1:0] x, input logic [W-1:0] y);
        logic [W:0] s;
        s = {1'b0, x} + {1'b0, y};
        oc_add = W'(s[W-1:0] + {{(W-1){1'b0}}, s[W]});
    endfunction : oc_add

    // ****************************************************************
    // State
    // ****************************************************************
    srx_pkg::srx_state_t state;
    srx_pkg::srx_state_t next_state;
    logic [5:0]  op_q;
    logic [2:0]  des_q;
    logic [A-1:0] m_q;
    logic [W-1:0] acc_q;
    logic [W-1:0] mask_q;
    logic [A-1:0] cur;
    logic         lower_q;
    logic         ovf_flag;
    logic         ovf_sel;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire [5:0]   in_op    = instr_word[23:srx_pkg::OP_LSB];
    wire [2:0]   in_des   = instr_word[srx_pkg::OP_LSB-1:srx_pkg::DES_LSB];
    wire [A-1:0] in_m     = instr_word[A-1:0];
    wire         take     = instr_valid && instr_ready;
    wire         is_search = (op_q[5:2] == srx_pkg::OP_EQU_SEARCH[5:2]);
    wire         is_masked = op_q[1];
    wire         is_thresh = op_q[0];
    wire         is_replace = (op_q[5:2] == srx_pkg::OP_REPL_ADD[5:2]);
    wire         is_exf    = (op_q == srx_pkg::OP_EXT_FUNC);
    wire         is_act    = is_exf && des_q != srx_pkg::DES_SELECT && des_q != srx_pkg::DES_SENSE;
    // Select/sense fields: channel, equipment, condition
    wire [2:0]   f_chan   = m_q[A-1:srx_pkg::CHAN_LSB];
    wire [2:0]   f_eqp    = m_q[srx_pkg::CHAN_LSB-1:srx_pkg::EQP_LSB];
    wire [8:0]   f_cond   = m_q[srx_pkg::EQP_LSB-1:0];
    wire         internal = (f_chan == 3'h0) && (f_eqp == 3'h0);

    // ****************************************************************
    // Search comparison
    // ****************************************************************
    wire [W-1:0] entry    = is_masked ? (mem_rdata & mask_q) : mem_rdata;
    wire         eq_hit   = (entry == acc_q) || (is_zero(entry) && is_zero(acc_q));
    wire         gt_hit   = order_key(entry) > order_key(acc_q);
    wire         hit      = is_thresh ? gt_hit : eq_hit;
    wire [A-1:0] cur_dec  = A'(cur - 1'b1);

    // ****************************************************************
    // Replace arithmetic
    // ****************************************************************
    wire [W-1:0] one_w    = {{(W-1){1'b0}}, 1'b1};
    // Subtraction adds the complement of the accumulator
    wire [W-1:0] addend   = (op_q == srx_pkg::OP_REPL_ADD) ? acc_q :
                            (op_q == srx_pkg::OP_REPL_SUB) ? ~acc_q :
                            (op_q == srx_pkg::OP_REPL_INC) ? one_w :
                            ~one_w;
    wire [W-1:0] repl_res = oc_add(mem_rdata, addend);
    wire         repl_ovf = (mem_rdata[W-1] == addend[W-1]) && (repl_res[W-1] != mem_rdata[W-1]);

    // ****************************************************************
    // Sense condition
    // ****************************************************************
    wire int_sense = (f_cond == srx_pkg::CC_OVF_FAULT) ? ovf_flag :
                     (f_cond == srx_pkg::CC_NO_OVF) ? !ovf_flag : 1'b0;
    wire sense_hit = internal ? int_sense : ext_cond;

    // Overflow indicator set and clear terms
    wire ovf_set   = (state == srx_pkg::SRX_READ) && mem_ack && is_replace && repl_ovf;
    wire sel_int   = (state == srx_pkg::SRX_SCAN) && is_exf && des_q == srx_pkg::DES_SELECT && internal;
    wire apb_wr    = psel && penable && pwrite;
    wire apb_ctrl  = apb_wr && paddr == srx_pkg::REG_CTRL;
    wire ovf_clr   = (apb_ctrl && pwdata[srx_pkg::CTRL_OVF_CLR]) || (sel_int && f_cond == srx_pkg::CC_CLR_FAULTS);

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        next_state = state;
        case (state)
            srx_pkg::SRX_IDLE:  next_state = take ? srx_pkg::SRX_SCAN : srx_pkg::SRX_IDLE;
            srx_pkg::SRX_SCAN: begin
                if (is_search)
                    next_state = (cur == '0) ? srx_pkg::SRX_DONE : srx_pkg::SRX_READ;
                else if (is_replace || is_act)
                    next_state = srx_pkg::SRX_READ;
                else
                    next_state = srx_pkg::SRX_DONE;
            end
            srx_pkg::SRX_READ: begin
                if (mem_ack)
                    next_state = (is_search && !hit) ? srx_pkg::SRX_SCAN :
                                 is_search ? srx_pkg::SRX_DONE : srx_pkg::SRX_WRITE;
            end
            srx_pkg::SRX_WRITE: next_state = mem_ack ? srx_pkg::SRX_DONE : srx_pkg::SRX_WRITE;
            srx_pkg::SRX_DONE:  next_state = srx_pkg::SRX_IDLE;
            default:            next_state = srx_pkg::SRX_IDLE;
        endcase
    end

    // Handshake outputs
    assign instr_ready  = (state == srx_pkg::SRX_IDLE);
    assign done         = (state == srx_pkg::SRX_DONE);
    assign mem_req      = (state == srx_pkg::SRX_READ) || (state == srx_pkg::SRX_WRITE);
    assign mem_we       = (state == srx_pkg::SRX_WRITE);
    assign overflow_irq = ovf_flag && ovf_sel;

    // ****************************************************************
    // State and instruction capture
    // ****************************************************************
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state   <= srx_pkg::SRX_IDLE;
            op_q    <= '0;
            des_q   <= '0;
            m_q     <= '0;
            acc_q   <= '0;
            mask_q  <= '0;
            lower_q <= 1'b0;
        end else begin
            state <= next_state;
            if (take) begin
                op_q    <= in_op;
                des_q   <= in_des;
                m_q     <= in_m;
                acc_q   <= acc_in;
                mask_q  <= mask_in;
                lower_q <= instr_lower;
            end
        end
    end

    // ****************************************************************
    // Scan index and storage address
    // ****************************************************************
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cur       <= '0;
            mem_addr  <= '0;
            mem_wdata <= '0;
            chan_term <= '0;
        end else begin
            if (take)
                cur <= (in_des == 3'h0) ? A'(1) : index_in;
            else if (state == srx_pkg::SRX_SCAN && is_search && cur != '0) begin
                cur      <= cur_dec;
                mem_addr <= A'(m_q + cur_dec);
            end else if (state == srx_pkg::SRX_SCAN && is_replace)
                mem_addr <= (des_q == 3'h0) ? m_q : A'(m_q + cur);
            else if (state == srx_pkg::SRX_SCAN && is_act)
                mem_addr <= A'(des_q);
            if (state == srx_pkg::SRX_READ && mem_ack && is_replace)
                mem_wdata <= repl_res;
            // Only the upper address field of the special word changes
            if (state == srx_pkg::SRX_READ && mem_ack && is_act) begin
                mem_wdata <= {mem_rdata[W-1:srx_pkg::UA_LSB+A], m_q, mem_rdata[srx_pkg::UA_LSB-1:0]};
                chan_term <= mem_rdata[A-1:0];
            end
        end
    end

    // ****************************************************************
    // Completion results
    // ****************************************************************
    wire fin_search = (state == srx_pkg::SRX_READ) && mem_ack && is_search && hit;
    wire fin_empty  = (state == srx_pkg::SRX_SCAN) && is_search && cur == '0;
    wire fin_write  = (state == srx_pkg::SRX_WRITE) && mem_ack;
    // Select, sense or an undecoded opcode: finishes straight from the scan state
    wire fin_exf    = (state == srx_pkg::SRX_SCAN) && !is_search && !is_replace && !is_act;
    wire is_sense   = is_exf && des_q == srx_pkg::DES_SENSE;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            exit_full <= 1'b0;
            exit_half <= 1'b0;
            acc_out   <= '0;
            acc_we    <= 1'b0;
            index_out <= '0;
            index_we  <= 1'b0;
        end else if (fin_search || fin_empty || fin_write || fin_exf) begin
            // Sense: exit on condition, half exit otherwise in both positions
            // Undecoded opcodes give a plain full exit
            exit_full <= fin_search || fin_write || (fin_exf && (!is_sense || sense_hit));
            exit_half <= fin_empty || (fin_exf && is_sense && !sense_hit);
            acc_out   <= fin_write && is_replace ? mem_wdata : acc_q;
            acc_we    <= fin_write && is_replace;
            index_out <= fin_search ? cur : '0;
            index_we  <= is_search && des_q != 3'h0;
        end
    end

    // ****************************************************************
    // Channel and condition strobes
    // ****************************************************************
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            chan_act    <= 1'b0;
            chan_num    <= '0;
            chan_start  <= '0;
            cond_select <= 1'b0;
            cond_code   <= '0;
        end else begin
            chan_act    <= fin_write && is_act;
            cond_select <= fin_exf && is_exf && des_q == srx_pkg::DES_SELECT;
            if (fin_write && is_act) begin
                chan_num   <= des_q;
                chan_start <= m_q;
            end
            if (fin_exf && is_exf)
                cond_code <= m_q;
        end
    end

    // ****************************************************************
    // Overflow indicator and selection
    // ****************************************************************
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ovf_flag <= 1'b0;
            ovf_sel  <= 1'b0;
        end else begin
            // Set wins over clear
            ovf_flag <= ovf_set || (ovf_flag && !ovf_clr);
            if (apb_ctrl)
                ovf_sel <= pwdata[srx_pkg::CTRL_OVF_SEL];
            else if (sel_int && f_cond == srx_pkg::CC_SEL_OVF_IRQ)
                ovf_sel <= 1'b1;
            else if (sel_int && f_cond == srx_pkg::CC_REM_OVF_IRQ)
                ovf_sel <= 1'b0;
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    wire hit_ctrl   = paddr == srx_pkg::REG_CTRL;
    wire hit_status = paddr == srx_pkg::REG_STATUS;
    wire hit_index  = paddr == srx_pkg::REG_INDEX;
    wire [31:0] st_word = {28'h0000000, exit_half, exit_full, !instr_ready, ovf_flag};
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !(hit_ctrl || hit_status || hit_index);
    assign prdata  = hit_ctrl   ? {31'h00000000, ovf_sel} :
                     hit_status ? st_word :
                     hit_index  ? {17'h00000, index_out} : 32'h00000000;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Search scan and exits
    a_match_index_addr: assert property (done && exit_full && is_search && des_q != 3'h0 |-> mem_addr == A'(m_q + index_out))
        else $error("matched entry address mismatch");
    a_scan_decrement: assert property (state == srx_pkg::SRX_SCAN && is_search && cur != '0 |=> cur == $past(cur) - 1'b1)
        else $error("index not decremented");
    a_empty_half_exit: assert property (state == srx_pkg::SRX_SCAN && is_search && cur == '0 |=> done && exit_half && !exit_full)
        else $error("exhausted search did not half exit");
    a_single_word: assert property (done && is_search && des_q == 3'h0 |-> !index_we)
        else $error("designator zero touched index");
    a_search_read_only: assert property (mem_req && is_search |-> !mem_we)
        else $error("search wrote storage");
    a_exit_exclusive: assert property (done |-> exit_full != exit_half)
        else $error("exit and half exit not exclusive");

    // Replace and overflow indicator
    a_replace_acc: assert property (done && is_replace |-> acc_we && acc_out == mem_wdata && exit_full)
        else $error("replace result not in accumulator");
    a_ovf_sticky: assert property (ovf_set |=> ovf_flag)
        else $error("overflow indicator lost");
    a_irq_select: assert property (!ovf_sel && !apb_ctrl && !sel_int |=> !overflow_irq)
        else $error("overflow interrupt not gated");
    a_ovf_clear: assert property (ovf_clr && !ovf_set |=> !ovf_flag)
        else $error("overflow indicator not cleared");

    // External function
    a_chan_start: assert property (chan_act |-> chan_start == m_q && mem_wdata[srx_pkg::UA_LSB+A-1:srx_pkg::UA_LSB] == m_q)
        else $error("block start not recorded");
    a_act_write: assert property (mem_we && is_act |-> mem_addr == A'(des_q) && mem_wdata[A-1:0] == chan_term)
        else $error("special word not kept");
    a_exf_no_index: assert property (done && is_exf |-> !index_we)
        else $error("external function touched index");
    a_sense_exit: assert property (state == srx_pkg::SRX_SCAN && is_exf && des_q == srx_pkg::DES_SENSE
                                   |=> done && exit_full == $past(sense_hit) && exit_half == !$past(sense_hit))
        else $error("sense exit wrong");

endmodule : srx_exec

`default_nettype wire

// ---- core/srx_pkg.sv ----
package srx_pkg;
    // ****************************************************************
    // Word and field layout
    // ****************************************************************
    localparam int WORD_W   = 48;
    localparam int ADDR_W   = 15;
    localparam int OP_LSB   = 18;
    localparam int DES_LSB  = 15;
    localparam int CHAN_LSB = 12;
    localparam int EQP_LSB  = 9;
    localparam int UA_LSB   = 24;

    // ****************************************************************
    // Function codes
    // ****************************************************************
    localparam logic [5:0] OP_EQU_SEARCH  = 6'h34;
    localparam logic [5:0] OP_THR_SEARCH  = 6'h35;
    localparam logic [5:0] OP_MEQ_SEARCH  = 6'h36;
    localparam logic [5:0] OP_MTH_SEARCH  = 6'h37;
    localparam logic [5:0] OP_REPL_ADD    = 6'h38;
    localparam logic [5:0] OP_REPL_SUB    = 6'h39;
    localparam logic [5:0] OP_REPL_INC    = 6'h3a;
    localparam logic [5:0] OP_REPL_DEC    = 6'h3b;
    localparam logic [5:0] OP_EXT_FUNC    = 6'h3c;

    localparam logic [2:0] DES_SELECT     = 3'h0;
    localparam logic [2:0] DES_SENSE      = 3'h7;

    // ****************************************************************
    // Internal condition codes (channel 0, equipment 0)
    // ****************************************************************
    localparam logic [8:0] CC_CLR_FAULTS  = 9'h038;
    localparam logic [8:0] CC_SEL_OVF_IRQ = 9'h040;
    localparam logic [8:0] CC_REM_OVF_IRQ = 9'h041;
    localparam logic [8:0] CC_OVF_FAULT   = 9'h058;
    localparam logic [8:0] CC_NO_OVF      = 9'h059;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] REG_CTRL      = 12'h000;
    localparam logic [11:0] REG_STATUS    = 12'h004;
    localparam logic [11:0] REG_INDEX     = 12'h008;
    localparam int CTRL_OVF_SEL   = 0;
    localparam int CTRL_OVF_CLR   = 1;
    localparam int ST_OVF         = 0;
    localparam int ST_BUSY        = 1;
    localparam int ST_FULL        = 2;
    localparam int ST_HALF        = 3;

    typedef enum logic [2:0] {
        SRX_IDLE  = 3'b000,
        SRX_SCAN  = 3'b001,
        SRX_READ  = 3'b010,
        SRX_WRITE = 3'b011,
        SRX_DONE  = 3'b100
    } srx_state_t;
endpackage : srx_pkg
